// ==== design/sadc_ctrl_top.sv ====
// converter control top: bus slave, control register, sequencer
`timescale 1ns/1ps
module sadc_ctrl_top
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // analog front end
  input  wire logic        comp_i,
  output logic [2:0]       chan_sel_o,
  output logic [9:0]       dac_code_o,
  output logic             busy_o
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  sadc_ctrl_t          ctrl;
  sadc_state_t         state;
  sadc_state_t         next_state;
  logic                wr_pend;
  logic [29:0]         wr_idx;
  logic                addr_ok;
  logic                wr_ctrl;
  logic                start_acc;
  logic                tick;
  logic [1:0]          run_speed;
  logic [1:0]          phase;
  logic [3:0]          bit_idx;
  logic                decide;
  logic                done_now;
  logic [RES_BITS-1:0] code;
  logic [RES_BITS-1:0] result;
  logic [11:0]         busy_cycles;

  // ------------------------------------------------------------
  // bus address phase
  // ------------------------------------------------------------

  // a transfer is taken only when the bus is ready
  assign addr_ok = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;

  // remember a write for its data phase
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
    end else begin
      wr_pend <= addr_ok && hwrite_i;
      wr_idx  <= haddr_i[31:2];
    end
  end

  // zero wait states, so out of reset the slave is always ready and okay
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= HRESP_OKAY;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= HRESP_OKAY;
    end
  end

  // read data is registered in the address phase; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hrdata_o <= '0;
    end else if (addr_ok && !hwrite_i) begin
      case (haddr_i[31:2])
        IDX_RES_HIGH: begin
          hrdata_o <= {24'h000000, result[9:2]};
        end
        IDX_RES_LOW: begin
          hrdata_o <= {24'h000000, result[1:0], 6'h00};
        end
        IDX_CONTROL: begin
          hrdata_o <= {24'h000000, ctrl};
        end
        default: begin
          hrdata_o <= '0;
        end
      endcase
    end else begin
      hrdata_o <= '0;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------

  // write to control in its data phase
  assign wr_ctrl = wr_pend && wr_idx == IDX_CONTROL;

  // a start is only taken while idle; the start bit of a write while busy is ignored
  assign start_acc = wr_ctrl && hwdata_i[START_BIT] && state == ST_IDLE;

  // channel and speed may change any time; flag is hardware-only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl <= sadc_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl.chan  <= hwdata_i[CHAN_LSB +: 3];
        ctrl.speed <= hwdata_i[SPEED_LSB +: 2];
      end
      if (start_acc) begin
        ctrl.start <= 1'b1;
        ctrl.eoc   <= 1'b0;
      end else if (done_now) begin
        ctrl.start <= 1'b0;
        ctrl.eoc   <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // per-conversion latches
  // ------------------------------------------------------------

  // channel and speed are frozen for the whole conversion
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chan_sel_o <= 3'h0;
      run_speed  <= SPD_DIV16;
    end else if (start_acc) begin
      chan_sel_o <= hwdata_i[CHAN_LSB +: 3];
      run_speed  <= hwdata_i[SPEED_LSB +: 2];
    end
  end

  // ------------------------------------------------------------
  // step clock
  // ------------------------------------------------------------
  sadc_step_div u_div (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .restart_i (start_acc),
    .speed_i   (run_speed),
    .tick_o    (tick)
  );

  // ------------------------------------------------------------
  // sequencer: one setup step, forty bit steps, one post step
  // ------------------------------------------------------------

  // the last phase of each bit makes that bit's decision
  assign decide   = state == ST_CONV && tick && phase == LAST_PHASE;
  assign done_now = state == ST_POST && tick;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_acc) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (decide && bit_idx == LAST_BIT) begin
          next_state = ST_POST;
        end
      end
      ST_POST: begin
        if (tick) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // step phase and bit counters
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || state == ST_IDLE) begin
      phase   <= 2'h0;
      bit_idx <= 4'h0;
    end else if (state == ST_CONV && tick) begin
      phase <= phase + 2'h1;
      if (phase == LAST_PHASE) begin
        bit_idx <= bit_idx + 4'h1;
      end
    end
  end

  // busy mirrors the sequencer but is a flop of its own
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= next_state != ST_IDLE;
    end
  end

  // ------------------------------------------------------------
  // approximation register
  // ------------------------------------------------------------
  sadc_sar u_sar (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .load_i    (start_acc),
    .decide_i  (decide),
    .comp_i    (comp_i),
    .code_o    (code)
  );

  assign dac_code_o = code;

  // ------------------------------------------------------------
  // result register
  // ------------------------------------------------------------

  // no protection of an unread result: the newest always wins
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      result <= '0;
    end else if (done_now) begin
      result <= code;
    end
  end

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------

  // clock edges since the start was taken
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || start_acc) begin
      busy_cycles <= 12'h000;
    end else if (state != ST_IDLE) begin
      busy_cycles <= busy_cycles + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_chan_route: assert property (
    start_acc |=> chan_sel_o == $past(hwdata_i[CHAN_LSB +: 3]))
    else $error("selected channel not routed at start");

  a_chan_held: assert property (
    busy_o && $past(busy_o) |-> $stable(chan_sel_o))
    else $error("channel changed during a conversion");

  a_start_clear: assert property (
    done_now |=> !ctrl.start && ctrl.eoc)
    else $error("start bit not cleared with done flag");

  a_eoc_cleared: assert property (
    start_acc |=> !ctrl.eoc ##1 !ctrl.eoc)
    else $error("done flag not cleared by start");

  a_eoc_only_done: assert property (
    !ctrl.eoc ##1 ctrl.eoc |-> $past(done_now))
    else $error("done flag set without completion");

  a_conv_length: assert property (
    done_now |->
      busy_cycles == 12'(TOTAL_STEPS) * 12'(sadc_div_len(run_speed)))
    else $error("conversion length is not 42 steps");

  a_result_load: assert property (
    done_now |=> result == $past(code))
    else $error("result not overwritten at completion");

  a_idle_stays: assert property (
    state == ST_IDLE && !start_acc |=> state == ST_IDLE)
    else $error("left idle without a start");

  a_post_idle: assert property (
    done_now |=> state == ST_IDLE && !busy_o)
    else $error("not idle after posting a result");

  c_conv_div1: cover property (
    start_acc && hwdata_i[SPEED_LSB +: 2] == SPD_DIV1 ##[1:60] done_now);

  c_conv_div16: cover property (
    run_speed == SPD_DIV16 && done_now);

  c_busy_start: cover property (
    wr_ctrl && hwdata_i[START_BIT] && state != ST_IDLE);

endmodule

// ==== design/sadc_pkg.sv ====
// shared constants and types for the converter control block
package sadc_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [29:0] IDX_RES_HIGH = 30'h003F0074;
  localparam logic [29:0] IDX_RES_LOW  = 30'h003F0075;
  localparam logic [29:0] IDX_CONTROL  = 30'h003F0076;

  // ------------------------------------------------------------
  // control register layout and reset
  // ------------------------------------------------------------
  localparam int          CHAN_LSB    = 4;
  localparam int          EOC_BIT     = 3;
  localparam int          SPEED_LSB   = 1;
  localparam int          START_BIT   = 0;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam int          RES_LOW_LSB = 6;

  // ------------------------------------------------------------
  // approximation sequence
  // ------------------------------------------------------------
  localparam int          RES_BITS      = 10;
  localparam logic [9:0]  SAR_MID       = 10'h200;
  localparam logic [1:0]  LAST_PHASE    = 2'h3;
  localparam logic [3:0]  LAST_BIT      = 4'h9;
  localparam int          STEPS_PER_BIT = 4;
  localparam int          SETUP_STEPS   = 2;
  localparam int          TOTAL_STEPS   =
    STEPS_PER_BIT * RES_BITS + SETUP_STEPS;

  // ------------------------------------------------------------
  // step clock divider selections
  // ------------------------------------------------------------
  localparam logic [1:0]  SPD_DIV16 = 2'h0;
  localparam logic [1:0]  SPD_DIV8  = 2'h1;
  localparam logic [1:0]  SPD_DIV4  = 2'h2;
  localparam logic [1:0]  SPD_DIV1  = 2'h3;

  // ------------------------------------------------------------
  // bus constants
  // ------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  // control register as stored
  typedef struct packed {
    logic       unused;
    logic [2:0] chan;
    logic       eoc;
    logic [1:0] speed;
    logic       start;
  } sadc_ctrl_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_CONV  = 2'b10,
    ST_POST  = 2'b11
  } sadc_state_t;

  // clock edges per step for a speed code
  function automatic logic [4:0] sadc_div_len(input logic [1:0] spd);
    case (spd)
      SPD_DIV16: sadc_div_len = 5'h10;
      SPD_DIV8:  sadc_div_len = 5'h08;
      SPD_DIV4:  sadc_div_len = 5'h04;
      default:   sadc_div_len = 5'h01;
    endcase
  endfunction

endpackage

// ==== design/sadc_step_div.sv ====
// step clock divider producing one tick per conversion step
`timescale 1ns/1ps
module sadc_step_div
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       restart_i,
  input  wire logic [1:0] speed_i,
  // step tick
  output logic            tick_o
);

  logic [3:0] cnt;
  logic [3:0] term;

  // terminal count is one less than the divide ratio
  assign term = 4'(sadc_div_len(speed_i) - 5'h01);

  // restart aligns the first step to the start write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || restart_i) begin
      cnt    <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt == term) begin
      cnt    <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 4'h1;
      tick_o <= 1'b0;
    end
  end

  a_div16_gap: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    tick_o && speed_i == SPD_DIV16 ##1 !restart_i |-> !tick_o[*8])
    else $error("ticks too close at divide by 16");

endmodule

// ==== design/sadc_sar.sv ====
// successive approximation register with bit-by-bit decisions
`timescale 1ns/1ps
module sadc_sar
  import sadc_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  // sequence control
  input  wire logic                load_i,
  input  wire logic                decide_i,
  input  wire logic                comp_i,
  // trial code to the resistor string
  output logic [RES_BITS-1:0]      code_o
);

  logic [RES_BITS-1:0] mask;

  // keep the trial bit when the input is at or above the trial level
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      code_o <= '0;
      mask   <= '0;
    end else if (load_i) begin
      code_o <= SAR_MID;
      mask   <= SAR_MID;
    end else if (decide_i) begin
      code_o <= (comp_i ? code_o : (code_o & ~mask)) | (mask >> 1);
      mask   <= mask >> 1;
    end
  end

  a_load_mid: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    load_i |=> code_o == SAR_MID)
    else $error("trial code not at midpoint after load");

endmodule

// ==== dv/sadc_front_model.sv ====
// behavioural analog front end: input levels, channel mux, comparator
`timescale 1ns/1ps
module sadc_front_model (
  // clock
  input  wire logic            clk_i,
  // ideal level of each analog input, as a code
  input  wire logic [7:0][9:0] level_i,
  // from the converter control
  input  wire logic [2:0]      chan_sel_i,
  input  wire logic [9:0]      dac_code_i,
  input  wire logic            busy_i,
  // comparator decision
  output logic                 comp_o
);
  logic churn = 1'b0;

  // outside a conversion the decision means nothing, so let it wander
  always @(posedge clk_i) begin
    churn <= ~churn;
  end

  // only the latched channel reaches the comparator; at or above keeps
  assign comp_o = busy_i ? (level_i[chan_sel_i] >= dac_code_i)
                         : churn;
endmodule

// ==== dv/sadc_ctrl_top_tb.sv ====
// self-checking bench for the converter control over its register bus
`timescale 1ns/1ps
module sadc_ctrl_top_tb
  import sadc_pkg::*;
;
  logic            clk       = 1'b0;
  logic            reset_n   = 1'b0;
  logic            hsel      = 1'b0;
  logic [31:0]     haddr     = 32'h0;
  logic [1:0]      htrans    = 2'h0;
  logic            hwrite    = 1'b0;
  logic [2:0]      hsize     = 3'h2;
  logic [31:0]     hwdata    = 32'h0;
  logic [31:0]     hrdata;
  logic            hreadyout;
  logic            hresp;
  logic            comp;
  logic [2:0]      chan_sel;
  logic [9:0]      dac_code;
  logic            busy;
  logic [7:0][9:0] level = {10'h3FE, 10'h001, 10'h2AA, 10'h155,
                            10'h1FF, 10'h200, 10'h3FF, 10'h000};
  int              n_mismatch = 0;
  int              cmp_count  = 0;

  // 50 MHz
  always #10 clk = ~clk;

  sadc_ctrl_top u_sadc_ctrl_top (
    .clk_i(clk), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .comp_i(comp),
    .chan_sel_o(chan_sel), .dac_code_o(dac_code), .busy_o(busy)
  );

  sadc_front_model u_sadc_front_model (
    .clk_i(clk), .level_i(level), .chan_sel_i(chan_sel),
    .dac_code_i(dac_code), .busy_i(busy), .comp_o(comp)
  );

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // bus master: hold each phase until ready is sampled high
  // ------------------------------------------------------------
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: bus never ready", $time);
      complete_run();
    end
  endtask

  task automatic bus(input logic wr, input logic [29:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    // the response must stay okay on every data phase
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic wr_reg(input logic [29:0] idx, input logic [31:0] wd);
    logic [31:0] v;
    bus(1'b1, idx, wd, v);
  endtask

  task automatic rd_chk(input logic [29:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    chk(v, exp);
  endtask

  // ------------------------------------------------------------
  // one conversion; optional start rewritten while busy
  // ------------------------------------------------------------
  task automatic run_conv(input logic [2:0] ch, input logic [1:0] spd,
                          input logic [2:0] ch2, input logic dbl,
                          input logic rd_res);
    logic [2:0] chf;
    logic [9:0] v;
    time        t0;
    int         len;
    int         n;
    chf = dbl ? ch2 : ch;
    len = (spd == 2'h0) ? 16 : (spd == 2'h1) ? 8 : (spd == 2'h2) ? 4 : 1;
    wr_reg(IDX_CONTROL, {25'h0, ch, 1'b0, spd, 1'b1});
    t0 = $time;
    // a level changed just before the call has landed by now
    v = level[ch];
    // outputs launched at the start edge are looked at one edge later
    @(posedge clk);
    chk({29'h0, chan_sel}, {29'h0, ch});
    chk({22'h0, dac_code}, 32'h200);
    if (dbl) begin
      wr_reg(IDX_CONTROL, {25'h0, ch2, 1'b0, spd, 1'b1});
      @(posedge clk);
      chk({29'h0, chan_sel}, {29'h0, ch});
    end
    rd_chk(IDX_CONTROL, {25'h0, chf, 1'b0, spd, 1'b1});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 800);
    if (busy !== 1'b0) begin
      n_mismatch++;
      $display("wrong value at %0t: conversion never ended", $time);
      complete_run();
    end
    chk(32'(($time - t0) / 20), 32'(42 * len + 2));
    rd_chk(IDX_CONTROL, {25'h0, chf, 1'b1, spd, 1'b0});
    if (rd_res) begin
      rd_chk(IDX_RES_HIGH, {24'h0, v[9:2]});
      rd_chk(IDX_RES_LOW, {24'h0, v[1:0], 6'h0});
    end
    $display("test conversion ch %0d speed %0d done", ch, spd);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    // reset values, read-only places and an unmapped word
    rd_chk(IDX_CONTROL, 32'h0);
    rd_chk(IDX_RES_HIGH, 32'h0);
    rd_chk(IDX_RES_LOW, 32'h0);
    rd_chk(IDX_CONTROL + 30'h1, 32'h0);
    wr_reg(IDX_RES_HIGH, 32'hFF);
    rd_chk(IDX_RES_HIGH, 32'h0);
    wr_reg(IDX_CONTROL, 32'h08);
    rd_chk(IDX_CONTROL, 32'h0);
    $display("test registers done");
    // every channel, every speed code twice
    for (int i = 0; i < 8; i++) begin
      run_conv(3'(i), 2'(i % 4), 3'(i), 1'b0, 1'b1);
    end
    // start rewritten mid-conversion with another channel
    run_conv(3'h2, 2'h3, 3'h5, 1'b1, 1'b1);
    // result left unread, then replaced by the next one
    run_conv(3'h4, 2'h3, 3'h4, 1'b0, 1'b0);
    level[4] <= 10'h0F3;
    run_conv(3'h4, 2'h2, 3'h4, 1'b0, 1'b1);
    complete_run();
  end
endmodule
